// [design/port1_defines.svh]
// Offsets, access maps and reset values of the port 1 block
`ifndef PORT1_DEFINES_SVH
`define PORT1_DEFINES_SVH

// CPU address width and space limits
`define CPU_ADDR_W 12
`define PERIPH_SPACE_FIRST 12'h000
`define PERIPH_SPACE_LAST 12'h03F
`define BUFFER_SPACE_FIRST 12'hF80
`define BUFFER_SPACE_LAST 12'hFFF

// Port 1 register offsets
`define PORT1_OUTPUT_LATCH_OFS 12'h001
`define PORT1_PIN_INPUT_OFS 12'h008
`define PORT1_SEGMENT_SELECT_OFS 12'h029

// Reset values
`define PORT1_OUTPUT_LATCH_RST 8'hFF
`define PORT1_SEGMENT_SELECT_RST 8'h00
`define PORT1_RDATA_RST 8'h00

// One bit per peripheral control location, indexed by the low six address bits
`define PERIPH_RESERVED_MASK 64'h000F_C0FC_CC80_0001
`define PERIPH_NO_READ_MASK 64'h0030_0000_0000_0000
`define PERIPH_NO_WRITE_MASK 64'h0000_0003_0040_2F00

// Buffer space, indexed by the low seven address bits
`define BUFFER_RESERVED_FIRST 7'h1B
`define BUFFER_NO_READ_MASK 32'h0500_0000

`endif

// [design/port1_pkg.sv]
// Types shared by the port 1 block
package port1_pkg;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_READ,
        ACC_WRITE
    } acc_state_t;

    typedef logic [7:0] port_byte_t;

endpackage

// [design/pin_sync.sv]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Only the second stage is visible outside
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule // pin_sync

// [design/port1_io_segment_select.sv]
// Port 1: output latch, pin input read path and segment select
//
// What this block does and what it expects of software and external sources
// R1: Peripheral control locations 000H to 03FH are decoded as CPU-reachable memory-mapped space.
// R2: Buffer locations F80H to FFFH are decoded as a second memory-mapped space.
// R3: Software keeps away from reserved locations and from blocked access directions.
// R4: Software uses no read-modify-write instructions on write-only or interrupt latch registers.
// R5: Each output bit holds its last written value in a latch until rewritten.
// R6: External sources hold input data until read, since pin inputs are not latched.
// R7: A port read samples the pin levels in the read sample state of the read cycle.
// R8: A port write changes the pin output data in the write update state of the write cycle.
// R9: The port offers eight independent bidirectional pins shared with secondary functions.
// R10: A pin whose segment select bit is 1 is handed to the segment driver.
// R11: For input or non-segment secondary use software sets the latch bit to 1 and select to 0.
// R12: For plain output use software clears the segment select bit so the latch reaches the pin.
// R13: Reset sets every bit of the output latch to 1.
// R14: Latch and pin input sit at separate addresses, returning stored and live values.
// R15: A pin input read of a segment pin gives an undefined value.
// R16: Outside segment mode the pin drive is the latch bit ANDed with the active-low secondary output.
`timescale 1ns/1ps
`include "port1_defines.svh"

module port1_io_segment_select #(
    parameter int PINS = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    input wire logic [`CPU_ADDR_W-1:0] CPU_ADDR,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire port1_pkg::port_byte_t CPU_WDATA,
    input wire logic READ_SAMPLE,
    input wire logic WRITE_UPDATE,
    output port1_pkg::port_byte_t CPU_RDATA,
    output logic CPU_RDATA_VALID,
    output logic CPU_BUSY,
    output logic PERIPH_SPACE_SEL,
    output logic BUFFER_SPACE_SEL,
    output logic ACCESS_FAULT,
    input wire logic [PINS-1:0] PIN_IN,
    output logic [PINS-1:0] PIN_OUT,
    output logic [PINS-1:0] PIN_OE,
    input wire logic [PINS-1:0] SEG_DATA,
    input wire logic [PINS-1:0] SEC_OUT_B,
    output logic [PINS-1:0] SEG_MODE,
    output logic [PINS-1:0] SEC_IN
);
    import port1_pkg::*;

    // Access sequencer
    acc_state_t state_reg;
    acc_state_t state_next;
    logic [`CPU_ADDR_W-1:0] addr_reg;
    logic [`CPU_ADDR_W-1:0] addr_next;
    port_byte_t wdata_reg;
    port_byte_t wdata_next;

    // Port state
    logic [PINS-1:0] latch_reg;
    logic [PINS-1:0] latch_next;
    logic [PINS-1:0] seg_reg;
    logic [PINS-1:0] seg_next;
    logic [PINS-1:0] pin_level;

    // Registered outputs
    port_byte_t rdata_reg;
    port_byte_t rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic fault_reg;
    logic fault_next;
    logic periph_sel_reg;
    logic buffer_sel_reg;
    logic [PINS-1:0] pin_out_reg;
    logic [PINS-1:0] pin_out_next;
    logic [PINS-1:0] pin_oe_reg;
    logic [PINS-1:0] pin_oe_next;
    logic [PINS-1:0] sec_in_reg;
    logic busy_reg;

    // Address decode
    logic periph_hit;
    logic buffer_hit;
    logic [5:0] periph_idx;
    logic [6:0] buffer_idx;
    logic periph_reserved;
    logic periph_no_read;
    logic periph_no_write;
    logic buffer_reserved;
    logic buffer_no_read;
    logic read_fault;
    logic write_fault;
    logic sel_latch;
    logic sel_pin_input;
    logic sel_segment;
    logic own_read_hit;

    // Sequencing events
    logic start_read;
    logic start_write;
    logic do_read;
    logic do_write;
    logic write_latch;
    logic write_segment;
    logic [PINS-1:0] normal_drive;
    logic [63:0] periph_reserved_mask;
    logic [63:0] periph_no_read_mask;
    logic [63:0] periph_no_write_mask;
    logic [31:0] buffer_no_read_mask;
    port_byte_t read_mux;

    // Pins come from outside the clock domain
    pin_sync #(
        .WIDTH(PINS),
        .RST_VAL({PINS{1'b1}})
    ) u_pin_sync (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .clk_en(CLK_EN),
        .async_in(PIN_IN),
        .sync_out(pin_level)
    ); // [R6]

    // Decode is taken from the address held at request time
    assign periph_hit = (addr_reg <= `PERIPH_SPACE_LAST); // [R1]
    assign buffer_hit = (addr_reg >= `BUFFER_SPACE_FIRST); // [R2]
    assign periph_idx = addr_reg[5:0];
    assign buffer_idx = addr_reg[6:0];
    // Maps held in named wires so they can be indexed
    assign periph_reserved_mask = `PERIPH_RESERVED_MASK;
    assign periph_no_read_mask = `PERIPH_NO_READ_MASK;
    assign periph_no_write_mask = `PERIPH_NO_WRITE_MASK;
    assign buffer_no_read_mask = `BUFFER_NO_READ_MASK;

    assign periph_reserved = periph_hit && periph_reserved_mask[periph_idx]; // [R3]
    assign periph_no_read = periph_hit && periph_no_read_mask[periph_idx]; // [R3]
    assign periph_no_write = periph_hit && periph_no_write_mask[periph_idx]; // [R3]
    assign buffer_reserved = buffer_hit && (buffer_idx >= `BUFFER_RESERVED_FIRST); // [R3]
    assign buffer_no_read = buffer_hit && !buffer_idx[6] && !buffer_idx[5]
                            && buffer_no_read_mask[buffer_idx[4:0]]; // [R3]

    // Holes between the two spaces count as faults as well
    assign read_fault = !(periph_hit || buffer_hit) || periph_reserved || buffer_reserved
                        || periph_no_read || buffer_no_read;
    assign write_fault = !(periph_hit || buffer_hit) || periph_reserved || buffer_reserved
                         || periph_no_write;

    // Latch and pin input have their own addresses
    assign sel_latch = (addr_reg == `PORT1_OUTPUT_LATCH_OFS); // [R14]
    assign sel_pin_input = (addr_reg == `PORT1_PIN_INPUT_OFS); // [R14]
    assign sel_segment = (addr_reg == `PORT1_SEGMENT_SELECT_OFS);
    assign own_read_hit = sel_latch || sel_pin_input || sel_segment;

    // Read wins when both strobes come together
    assign start_read = (state_reg == ACC_IDLE) && CPU_RD;
    assign start_write = (state_reg == ACC_IDLE) && CPU_WR && !CPU_RD;
    assign do_read = (state_reg == ACC_READ) && READ_SAMPLE; // [R7]
    assign do_write = (state_reg == ACC_WRITE) && WRITE_UPDATE; // [R8]

    // Writes to the pin input address change nothing; the no-write map only flags a fault
    assign write_latch = do_write && sel_latch; // [R8]
    assign write_segment = do_write && sel_segment;

    // Segment pins read whatever the pad shows; software must ignore it
    assign read_mux = sel_latch ? port_byte_t'(latch_reg) :
                      sel_pin_input ? port_byte_t'(pin_level) : // [R7] [R15]
                      sel_segment ? port_byte_t'(seg_reg) :
                      `PORT1_RDATA_RST;

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        case (state_reg)
            ACC_IDLE: begin
                if (start_read) begin
                    state_next = ACC_READ;
                    addr_next = CPU_ADDR;
                end else if (start_write) begin
                    state_next = ACC_WRITE;
                    addr_next = CPU_ADDR;
                    wdata_next = CPU_WDATA;
                end
            end
            ACC_READ: begin
                if (READ_SAMPLE) begin
                    state_next = ACC_IDLE;
                end
            end
            ACC_WRITE: begin
                if (WRITE_UPDATE) begin
                    state_next = ACC_IDLE;
                end
            end
            default: begin
                state_next = ACC_IDLE;
            end
        endcase
    end

    // Latch keeps its value unless a write lands on it
    assign latch_next = write_latch ? wdata_reg[PINS-1:0] : latch_reg; // [R5]
    assign seg_next = write_segment ? wdata_reg[PINS-1:0] : seg_reg; // [R10]

    assign rdata_next = do_read ? read_mux : rdata_reg;
    assign rvalid_next = do_read && own_read_hit; // [R14]
    assign fault_next = (do_read && read_fault) || (do_write && write_fault);

    // Latch at 1 releases the line to the secondary function or the outside
    assign normal_drive = latch_next & SEC_OUT_B; // [R16]

    // Segment bits hand the pad to the segment driver outright
    assign pin_out_next = (seg_next & SEG_DATA) | (~seg_next & normal_drive); // [R9] [R10]

    // Open-drain style: a 1 outside segment mode is not driven
    assign pin_oe_next = seg_next | ~normal_drive; // [R9] [R16]

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            state_reg <= ACC_IDLE;
            addr_reg <= `PERIPH_SPACE_FIRST;
            wdata_reg <= `PORT1_RDATA_RST;
        end else if (CLK_EN) begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            latch_reg <= `PORT1_OUTPUT_LATCH_RST; // [R13]
            seg_reg <= `PORT1_SEGMENT_SELECT_RST;
        end else if (CLK_EN) begin
            latch_reg <= latch_next; // [R5]
            seg_reg <= seg_next;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            rdata_reg <= `PORT1_RDATA_RST;
            rvalid_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else if (CLK_EN) begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            fault_reg <= fault_next;
        end
    end

    // Space selects follow the held address while an access is open
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            busy_reg <= 1'b0;
            periph_sel_reg <= 1'b0;
            buffer_sel_reg <= 1'b0;
        end else if (CLK_EN) begin
            // Own flop, so the busy output never glitches on state decode
            busy_reg <= (state_next != ACC_IDLE);
            periph_sel_reg <= (state_next != ACC_IDLE) && (addr_next <= `PERIPH_SPACE_LAST); // [R1]
            buffer_sel_reg <= (state_next != ACC_IDLE) && (addr_next >= `BUFFER_SPACE_FIRST); // [R2]
        end
    end

    // Reset drive equals latch all ones with pads released
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            pin_out_reg <= {PINS{1'b1}};
            pin_oe_reg <= {PINS{1'b0}};
            sec_in_reg <= {PINS{1'b1}};
        end else if (CLK_EN) begin
            pin_out_reg <= pin_out_next; // [R8]
            pin_oe_reg <= pin_oe_next;
            sec_in_reg <= pin_level; // [R9]
        end
    end

    assign CPU_RDATA = rdata_reg;
    assign CPU_RDATA_VALID = rvalid_reg;
    assign CPU_BUSY = busy_reg;
    assign PERIPH_SPACE_SEL = periph_sel_reg;
    assign BUFFER_SPACE_SEL = buffer_sel_reg;
    assign ACCESS_FAULT = fault_reg;
    assign PIN_OUT = pin_out_reg;
    assign PIN_OE = pin_oe_reg;
    assign SEG_MODE = seg_reg;
    assign SEC_IN = sec_in_reg;

endmodule // port1_io_segment_select

// [test/port1_checker.sv]
// Bus timing and pin drive checker for port 1
`timescale 1ns/1ps
`include "port1_defines.svh"
module port1_checker #(
    parameter int PINS = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic CLK_EN,
    input wire logic [`CPU_ADDR_W-1:0] CPU_ADDR,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire logic READ_SAMPLE,
    input wire logic WRITE_UPDATE,
    input wire logic CPU_RDATA_VALID,
    input wire logic CPU_BUSY,
    input wire logic PERIPH_SPACE_SEL,
    input wire logic BUFFER_SPACE_SEL,
    input wire logic ACCESS_FAULT,
    input wire logic [PINS-1:0] PIN_OUT,
    input wire logic [PINS-1:0] PIN_OE,
    input wire logic [PINS-1:0] SEG_DATA,
    input wire logic [PINS-1:0] SEC_OUT_B,
    input wire logic [PINS-1:0] SEG_MODE
);
    logic is_read_reg;
    logic [`CPU_ADDR_W-1:0] addr_reg;
    wire logic take = CLK_EN && !CPU_BUSY && (CPU_RD || CPU_WR);
    wire logic own_addr = addr_reg == `PORT1_OUTPUT_LATCH_OFS || addr_reg == `PORT1_PIN_INPUT_OFS
        || addr_reg == `PORT1_SEGMENT_SELECT_OFS;
    // Shadow of the open access, so completions can be judged by kind
    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            is_read_reg <= 1'b0;
            addr_reg <= '0;
        end else if (take) begin
            is_read_reg <= CPU_RD;
            addr_reg <= CPU_ADDR;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    chk_reset_state: assert property ($rose(RST_B) |-> PIN_OUT == 8'hFF && PIN_OE == 8'h00 && SEG_MODE == 8'h00)
        else $error("pins not at reset state");
    chk_take_busy: assert property (take |=> CPU_BUSY)
        else $error("request not taken");
    chk_space_sel: assert property (CPU_BUSY |-> PERIPH_SPACE_SEL == (addr_reg <= `PERIPH_SPACE_LAST)
        && BUFFER_SPACE_SEL == (addr_reg >= `BUFFER_SPACE_FIRST)) else $error("space select wrong");
    chk_busy_wait: assert property (CLK_EN && CPU_BUSY && !READ_SAMPLE && !WRITE_UPDATE |=> CPU_BUSY)
        else $error("access ended without strobe");
    chk_read_done: assert property (CLK_EN && CPU_BUSY && READ_SAMPLE && is_read_reg && own_addr
        |=> CPU_RDATA_VALID && !CPU_BUSY && !ACCESS_FAULT) else $error("port read not completed");
    chk_write_done: assert property (CLK_EN && CPU_BUSY && WRITE_UPDATE && !is_read_reg
        |=> !CPU_BUSY && !CPU_RDATA_VALID && (ACCESS_FAULT || addr_reg != `PORT1_PIN_INPUT_OFS))
        else $error("write not completed");
    chk_seg_drive: assert property (CLK_EN && !WRITE_UPDATE |=> ((PIN_OUT ^ $past(SEG_DATA)) & $past(SEG_MODE)) == 8'h00
        && (PIN_OE & $past(SEG_MODE)) == $past(SEG_MODE)) else $error("segment pin drive wrong");
    chk_sec_drive: assert property (CLK_EN && !WRITE_UPDATE |=> (PIN_OUT & ~$past(SEC_OUT_B) & ~$past(SEG_MODE)) == 8'h00
        && ((PIN_OE ^ ~PIN_OUT) & ~$past(SEG_MODE)) == 8'h00) else $error("port pin drive wrong");
    cover property (CPU_RDATA_VALID);
    cover property (ACCESS_FAULT);
    cover property (BUFFER_SPACE_SEL && CPU_BUSY);
endmodule // port1_checker

bind port1_io_segment_select port1_checker #(.PINS(PINS)) u_checker (.*);

// [test/port1_pads.sv]
// Pad ring model: pull-ups and an external source per pin
`timescale 1ns/1ps
module port1_pads #(
    parameter int PINS = 8
) (
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] ext_val,
    input wire logic [PINS-1:0] ext_en,
    output logic [PINS-1:0] pin_in
);
    // Undriven pins float to the pull-up; external level held as set
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule // port1_pads

// [test/port1_io_segment_select_test.sv]
// Self-checking bench for port 1
`timescale 1ns/1ps
module port1_io_segment_select_test;
    import port1_pkg::*;
    logic CORE_CLK, RST_B, CLK_EN, CPU_RD, CPU_WR, READ_SAMPLE, WRITE_UPDATE, v, f;
    logic CPU_RDATA_VALID, CPU_BUSY, PERIPH_SPACE_SEL, BUFFER_SPACE_SEL, ACCESS_FAULT;
    logic [11:0] CPU_ADDR;
    port_byte_t CPU_WDATA, CPU_RDATA, PIN_IN, PIN_OUT, PIN_OE, SEG_DATA, SEC_OUT_B, SEG_MODE, SEC_IN;
    port_byte_t ext_val, ext_en, rd;
    int err_count, checks;
    logic [11:0] bad_addr [7] = '{12'h008, 12'h000, 12'h040, 12'hF80, 12'hF98, 12'hFC0, 12'h03F};
    logic [6:0] bad_wr = 7'h05;
    logic [6:0] bad_flt = 7'h37;

    port1_io_segment_select u_dut (.*);
    port1_pads u_pads (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_val(ext_val), .ext_en(ext_en), .pin_in(PIN_IN));

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    task automatic conclude();
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input port_byte_t seen, input port_byte_t exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One access; gap stretches the wait before the sequencer strobe
    task automatic acc(input logic wr, input logic [11:0] a, input port_byte_t d, input int gap);
        @(posedge CORE_CLK) #1;
        CPU_ADDR = a;
        CPU_WDATA = d;
        CPU_RD = !wr;
        CPU_WR = wr;
        @(posedge CORE_CLK) #1;
        CPU_RD = 1'b0;
        CPU_WR = 1'b0;
        repeat (gap) @(posedge CORE_CLK) #1;
        READ_SAMPLE = !wr;
        WRITE_UPDATE = wr;
        @(posedge CORE_CLK) #1;
        READ_SAMPLE = 1'b0;
        WRITE_UPDATE = 1'b0;
        rd = CPU_RDATA;
        v = CPU_RDATA_VALID;
        f = ACCESS_FAULT;
    endtask

    task automatic rd_exp(input logic [11:0] a, input port_byte_t e, input int gap);
        acc(1'b0, a, 8'h00, gap);
        chk(rd, e);
        chk(v, 8'h01);
    endtask

    initial begin
        #20000;
        err_count++;
        conclude();
    end

    initial begin
        {CLK_EN, RST_B, CPU_RD, CPU_WR, READ_SAMPLE, WRITE_UPDATE} = 6'h20;
        CPU_ADDR = 12'h000;
        CPU_WDATA = 8'h00;
        SEG_DATA = 8'hA5;
        SEC_OUT_B = 8'hFF;
        ext_val = 8'h00;
        ext_en = 8'h00;
        err_count = 0;
        checks = 0;
        repeat (2) @(posedge CORE_CLK);
        #1 RST_B = 1'b1;
        chk(PIN_OUT, 8'hFF);
        chk(PIN_OE, 8'h00);
        rd_exp(12'h001, 8'hFF, 0);
        rd_exp(12'h029, 8'h00, 0);
        acc(1'b1, 12'h001, 8'h5A, 0); // Whole-byte writes only
        chk(PIN_OUT, 8'h5A);
        chk(PIN_OE, 8'hA5);
        repeat (5) @(posedge CORE_CLK) #1;
        rd_exp(12'h001, 8'h5A, 6);
        SEC_OUT_B = 8'hBF;
        @(posedge CORE_CLK) #1;
        chk(PIN_OUT, 8'h1A);
        chk(PIN_OE, 8'hE5);
        SEC_OUT_B = 8'hFF;
        acc(1'b1, 12'h001, 8'hFF, 0); // Latch 1, select 0 for input use
        ext_en = 8'hFF;
        for (int i = 0; i < 8; i++) begin
            ext_val = 8'h01 << i;
            repeat (3) @(posedge CORE_CLK) #1;
            rd_exp(12'h008, ext_val, 0);
            chk(SEC_IN, ext_val);
        end
        ext_en = 8'h00;
        acc(1'b1, 12'h029, 8'hF0, 0);
        @(posedge CORE_CLK) #1;
        chk(SEG_MODE, 8'hF0);
        chk(PIN_OUT, 8'hAF);
        chk(PIN_OE, 8'hF0);
        SEG_DATA = 8'h5A;
        @(posedge CORE_CLK) #1;
        chk(PIN_OUT, 8'h5F);
        acc(1'b0, 12'h008, 8'h00, 0);
        chk(rd & 8'h0F, 8'h0F);
        acc(1'b1, 12'h029, 8'h00, 0);
        acc(1'b1, 12'h001, 8'h5A, 0);
        chk(PIN_OUT, 8'h5A);
        for (int i = 0; i < 7; i++) begin
            acc(bad_wr[i], bad_addr[i], 8'h33, 0);
            chk(f, {7'h00, bad_flt[i]});
            chk(v, 8'h00);
            if (!bad_wr[i] && !bad_flt[i]) chk(rd, 8'h00);
        end
        rd_exp(12'h001, 8'h5A, 0);
        // Clock enable low: request and strobe must both be ignored
        CLK_EN = 1'b0;
        acc(1'b1, 12'h001, 8'h0F, 0);
        CLK_EN = 1'b1;
        chk(PIN_OUT, 8'h5A);
        rd_exp(12'h001, 8'h5A, 0);
        @(posedge CORE_CLK) #1;
        RST_B = 1'b0;
        @(posedge CORE_CLK) #1;
        RST_B = 1'b1;
        rd_exp(12'h001, 8'hFF, 0);
        chk(SEG_MODE, 8'h00);
        conclude();
    end
endmodule // port1_io_segment_select_test
